// [hw/irq_unit_pkg.sv]
package irq_unit_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] OPTION_OFFSET    = 8'hc8;
  localparam logic [7:0] OPTION_RESET     = 8'h00;
  localparam int         LVL_SEL_BIT      = 6;
  localparam int         POL_SEL_BIT      = 5;
  localparam int         ENABLE_BIT       = 4;
  localparam logic [7:0] OPTION_USED_MASK = 8'h70;

  // ==========================================================================
  // Vector addresses, program space
  localparam logic [11:0] VEC_SRC0       = 12'hffc;
  localparam logic [11:0] VEC_SRC1       = 12'hff6;
  localparam logic [11:0] VEC_SRC2       = 12'hff4;
  localparam logic [11:0] VEC_SRC3       = 12'hff2;
  localparam logic [11:0] VEC_SRC4       = 12'hff0;

  // ==========================================================================
  // Timing
  localparam int          LDI_CYCLES     = 4;
  localparam int          LDI_RACE_CYC   = 3;

  // Flag set selection
  typedef enum logic [1:0] {
    FSET_NORMAL  = 2'b00,
    FSET_SERVICE = 2'b01,
    FSET_NMI     = 2'b10
  } flag_set_t;

  // Entry sequencer states
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_SWAP   = 3'b001,
    ST_PUSH   = 3'b010,
    ST_CLEAR  = 3'b011,
    ST_VECTOR = 3'b100
  } entry_state_t;

endpackage

// [hw/req_sync.sv]
`timescale 1ns/1ps
// ============================================================================
// Two-flop synchroniser for request lines
module req_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_ff;

  // First stage read only by second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= '1;
      dout    <= '1;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule

// [hw/edge_latch.sv]
`timescale 1ns/1ps
// ============================================================================
// Single pending latch for an edge-sensitive source
module edge_latch (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic line,
  input  wire logic rising,
  input  wire logic enable,
  input  wire logic clear,
  output logic      pending
);
  logic prev_ff;
  logic hit;

  // Selected polarity edge
  assign hit = enable && (rising ? (line && !prev_ff) : (!line && prev_ff));

  always_ff @(posedge clk) begin
    if (!rst_n) prev_ff <= 1'b1;
    else        prev_ff <= line;
  end

  // Holds one request; set beats clear
  always_ff @(posedge clk) begin
    if (!rst_n)     pending <= 1'b0;
    else if (hit)   pending <= 1'b1;
    else if (clear) pending <= 1'b0;
  end
endmodule

// [hw/irq_request_unit.sv]
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module irq_request_unit
  import irq_unit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Core handshake
  input  wire logic        instr_end,
  input  wire logic        ldi_option_clear,
  input  wire logic [1:0]  ldi_cycle,
  input  wire logic        return_from_service,
  input  wire logic        core_sleeping,
  input  wire logic [11:0] pc_in,
  output logic             wake_up,
  output logic             irq_taken,
  output logic             pc_push,
  output logic [11:0]      pc_push_data,
  output logic             pc_pop,
  output logic             pc_load,
  output logic [11:0]      pc_load_data,
  output logic [1:0]       flag_set,
  output logic [2:0]       active_source,
  // Pins
  input  wire logic [7:0]  port_a_irq,
  input  wire logic [7:0]  port_b_irq,
  input  wire logic [7:0]  port_c_irq,
  input  wire logic [7:0]  port_d_irq,
  // Peripheral events and their masks
  input  wire logic        timer_zero_event,
  input  wire logic        timer_irq_mask,
  input  wire logic        conv_done_event,
  input  wire logic        converter_irq_mask,
  input  wire logic        byte_received_event,
  input  wire logic        receive_irq_mask,
  input  wire logic        byte_sent_event,
  input  wire logic        transmit_irq_mask,
  input  wire logic        reload_overflow_event,
  input  wire logic        reload_overflow_mask,
  input  wire logic        reload_compare_event,
  input  wire logic        reload_compare_mask,
  input  wire logic        reload_edge_event,
  input  wire logic        reload_edge_mask,
  input  wire logic        sync_serial_done_n
);
  import irq_unit_pkg::*;

  // ==========================================================================
  // Option register
  logic [7:0]     interrupt_option_reg_ff;
  logic           global_irq_enable;
  logic           level_edge_select;
  logic           edge_polarity_select;

  // Write-only; unused bits kept zero
  always_ff @(posedge clk) begin
    if (!rst_n)
      interrupt_option_reg_ff <= OPTION_RESET;
    else if (reg_wr && reg_addr == OPTION_OFFSET)
      interrupt_option_reg_ff <= reg_wdata & OPTION_USED_MASK;
  end

  assign global_irq_enable    = interrupt_option_reg_ff[ENABLE_BIT];
  assign level_edge_select    = interrupt_option_reg_ff[LVL_SEL_BIT];
  assign edge_polarity_select = interrupt_option_reg_ff[POL_SEL_BIT];

  // Reads return zero: register is write-only
  always_ff @(posedge clk) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else        reg_rdata <= 8'h00;
  end

  // ==========================================================================
  // Pin synchronisers and routing
  logic [3:0] pin_raw;
  logic [3:0] pin_sync;

  // Active-low wired requests per source pin group
  assign pin_raw = {&port_d_irq, &port_c_irq, &port_b_irq,
                    &port_a_irq & sync_serial_done_n};

  req_sync #(.WIDTH(4)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (pin_raw),
    .dout  (pin_sync)
  );

  logic src1_line;
  logic src2_line;
  logic src0_line;
  logic src3_req;
  logic src4_req;

  assign src1_line = pin_sync[0];
  assign src2_line = pin_sync[1] & pin_sync[3];
  assign src0_line = pin_sync[2];
  // Peripheral requests, each under its own mask
  assign src3_req  = (reload_overflow_event & reload_overflow_mask) |
                     (reload_compare_event & reload_compare_mask) |
                     (reload_edge_event & reload_edge_mask);
  assign src4_req  = (timer_zero_event & timer_irq_mask) |
                     (conv_done_event & converter_irq_mask) |
                     (byte_received_event & receive_irq_mask) |
                     (byte_sent_event & transmit_irq_mask);

  // ==========================================================================
  // Pending latches
  entry_state_t state_ff;
  logic [2:0]   sel_ff;
  logic         clr_nmi;
  logic         clr_src1;
  logic         clr_src2;
  logic         nmi_pend;
  logic         src1_edge_pend;
  logic         src2_pend;
  logic         src1_pend;

  assign clr_nmi  = state_ff == ST_CLEAR && sel_ff == 3'd0;
  assign clr_src1 = (state_ff == ST_CLEAR && sel_ff == 3'd1) || level_edge_select;
  assign clr_src2 = state_ff == ST_CLEAR && sel_ff == 3'd2;

  edge_latch u_nmi (
    .clk     (clk),
    .rst_n   (rst_n),
    .line    (src0_line),
    .rising  (1'b0),
    .enable  (1'b1),
    .clear   (clr_nmi),
    .pending (nmi_pend)
  );

  edge_latch u_src1 (
    .clk     (clk),
    .rst_n   (rst_n),
    .line    (src1_line),
    .rising  (1'b0),
    .enable  (!level_edge_select),
    .clear   (clr_src1),
    .pending (src1_edge_pend)
  );

  edge_latch u_src2 (
    .clk     (clk),
    .rst_n   (rst_n),
    .line    (src2_line),
    .rising  (edge_polarity_select),
    .enable  (1'b1),
    .clear   (clr_src2),
    .pending (src2_pend)
  );

  // Level mode reads the line directly, nothing stored
  assign src1_pend = level_edge_select ? !src1_line : src1_edge_pend;

  // ==========================================================================
  // Service nesting and priority
  logic       in_service_ff;
  logic       in_nmi_ff;
  logic       nested_nmi_ff;
  logic [1:0] saved_set_ff;
  logic       mask_ok;
  logic       take;
  logic [2:0] pick;

  // Maskable only when enabled and no routine runs
  assign mask_ok = global_irq_enable && !in_service_ff && !in_nmi_ff;

  // Fixed priority selection
  always_comb begin
    pick = 3'd7;
    if (nmi_pend && !in_nmi_ff) pick = 3'd0;
    else if (mask_ok && src1_pend) pick = 3'd1;
    else if (mask_ok && src2_pend) pick = 3'd2;
    else if (mask_ok && src3_req)  pick = 3'd3;
    else if (mask_ok && src4_req)  pick = 3'd4;
  end

  // Decision at instruction boundary
  assign take = state_ff == ST_RUN && instr_end && pick != 3'd7;

  // Wake only under global enable
  assign wake_up = core_sleeping && global_irq_enable &&
                   (nmi_pend || src1_pend || src2_pend || src3_req || src4_req);

  // Vector lookup
  function automatic logic [11:0] vec_of(input logic [2:0] s);
    case (s)
      3'd0:    vec_of = VEC_SRC0;
      3'd1:    vec_of = VEC_SRC1;
      3'd2:    vec_of = VEC_SRC2;
      3'd3:    vec_of = VEC_SRC3;
      default: vec_of = VEC_SRC4;
    endcase
  endfunction

  // Race with option-clearing load skips the flag swap
  logic race_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) race_ff <= 1'b0;
    else if (take)
      race_ff <= ldi_option_clear && pick != 3'd0 &&
                 ldi_cycle < 2'(LDI_RACE_CYC);
  end

  // ==========================================================================
  // Entry sequencer
  entry_state_t nxt_state;
  always_comb begin
    case (state_ff)
      ST_RUN:    nxt_state = take ? ST_SWAP : ST_RUN;
      ST_SWAP:   nxt_state = ST_PUSH;
      ST_PUSH:   nxt_state = ST_CLEAR;
      ST_CLEAR:  nxt_state = ST_VECTOR;
      ST_VECTOR: nxt_state = ST_RUN;
      default:   nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state_ff <= ST_RUN;
    else        state_ff <= nxt_state;
  end

  always_ff @(posedge clk) begin
    if (!rst_n)    sel_ff <= 3'd0;
    else if (take) sel_ff <= pick;
  end

  assign irq_taken     = take;
  assign active_source = sel_ff;
  assign pc_push       = state_ff == ST_PUSH;
  assign pc_push_data  = pc_in;
  assign pc_load       = state_ff == ST_VECTOR;
  assign pc_load_data  = vec_of(sel_ff);
  assign pc_pop        = return_from_service && state_ff == ST_RUN;

  // ==========================================================================
  // Mode and flag-set tracking
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_service_ff <= 1'b0;
      in_nmi_ff     <= 1'b0;
      nested_nmi_ff <= 1'b0;
      saved_set_ff  <= FSET_NORMAL;
      flag_set      <= FSET_NORMAL;
    end else if (state_ff == ST_SWAP) begin
      saved_set_ff <= flag_set;
      if (sel_ff == 3'd0) begin
        in_nmi_ff     <= 1'b1;
        nested_nmi_ff <= in_service_ff;
        flag_set      <= FSET_NMI;
      end else begin
        in_service_ff <= 1'b1;
        if (!race_ff)
          flag_set <= FSET_SERVICE;
      end
    end else if (pc_pop) begin
      // Restore previous set on return
      flag_set <= saved_set_ff;
      if (in_nmi_ff) begin
        in_nmi_ff    <= 1'b0;
        saved_set_ff <= FSET_NORMAL;
        if (!nested_nmi_ff) in_service_ff <= 1'b0;
      end else begin
        in_service_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  sequence entry_seq;
    take ##1 state_ff == ST_SWAP ##1 pc_push ##1 state_ff == ST_CLEAR ##1 pc_load;
  endsequence

  entry_order_a: assert property (@(posedge clk) disable iff (!rst_n)
    take |-> entry_seq) else $error("entry steps out of order");
  gen_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && !global_irq_enable |-> pick == 3'd0) else $error("masked source taken");
  wake_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    wake_up |-> global_irq_enable) else $error("wake without enable");
  nmi_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_CLEAR && sel_ff == 3'd0 && !(u_nmi.hit) |=> !nmi_pend)
    else $error("nmi latch not cleared");
  vec_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && pick == 3'd1 |-> ##4 pc_load_data == VEC_SRC1) else $error("bad vector");
  no_nest_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && in_service_ff |-> pick == 3'd0) else $error("maskable nested");
  flag_swap_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && pick == 3'd0 |-> ##2 flag_set == FSET_NMI) else $error("no nmi flag set");
  opt_reset_a: assert property (@(posedge clk)
    !rst_n |=> interrupt_option_reg_ff == OPTION_RESET) else $error("option not reset");
  prio_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && mask_ok && src1_pend && !nmi_pend |-> pick == 3'd1)
    else $error("priority wrong");
endmodule

// [dv/core_model.sv]
`timescale 1ns/1ps
// ============================================================================
// Core stand-in: ends instructions, holds the program counter and one stack level
module core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic        pc_push,
  input  wire logic [11:0] pc_push_data,
  input  wire logic        pc_pop,
  input  wire logic        pc_load,
  input  wire logic [11:0] pc_load_data,
  output logic             instr_end,
  output logic      [11:0] pc
);
  logic [1:0]  cnt_ff;
  logic [11:0] pc_ff;
  logic [11:0] stack_ff;

  // Three-cycle instructions while running
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_ff <= 2'h0;
    end else begin
      cnt_ff <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
    end
  end
  assign instr_end = run && (cnt_ff == 2'h2);

  // Program counter with vector load and return pop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_ff <= 12'h100;
    end else if (pc_load) begin
      pc_ff <= pc_load_data;
    end else if (pc_pop) begin
      pc_ff <= stack_ff;
    end else if (instr_end) begin
      pc_ff <= pc_ff + 12'h001;
    end
  end
  assign pc = pc_ff;

  // First stack level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_ff <= 12'h000;
    end else if (pc_push) begin
      stack_ff <= pc_push_data;
    end
  end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top;
  import irq_unit_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, ldi_option_clear, return_from_service, core_sleeping;
  logic run, sync_serial_done_n;
  logic [7:0] reg_addr, reg_wdata, port_a_irq, port_b_irq, port_c_irq, port_d_irq;
  logic [1:0] ldi_cycle;
  logic [6:0] ev, mk;
  wire logic [11:0] pc_in, pc_push_data, pc_load_data;
  wire logic instr_end, wake_up, irq_taken, pc_push, pc_pop, pc_load;
  wire logic [7:0] reg_rdata;
  wire logic [1:0] flag_set;
  wire logic [2:0] active_source;
  int bad_count, samples_checked, cyc;

  irq_request_unit irq_request_unit_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .instr_end, .ldi_option_clear, .ldi_cycle, .return_from_service,
    .core_sleeping, .pc_in, .wake_up, .irq_taken, .pc_push, .pc_push_data, .pc_pop,
    .pc_load, .pc_load_data, .flag_set, .active_source, .port_a_irq, .port_b_irq,
    .port_c_irq, .port_d_irq, .timer_zero_event(ev[0]), .timer_irq_mask(mk[0]),
    .conv_done_event(ev[1]), .converter_irq_mask(mk[1]), .byte_received_event(ev[2]),
    .receive_irq_mask(mk[2]), .byte_sent_event(ev[3]), .transmit_irq_mask(mk[3]),
    .reload_overflow_event(ev[4]), .reload_overflow_mask(mk[4]),
    .reload_compare_event(ev[5]), .reload_compare_mask(mk[5]),
    .reload_edge_event(ev[6]), .reload_edge_mask(mk[6]), .sync_serial_done_n);
  core_model core_model_inst (.clk, .rst_n, .run, .pc_push, .pc_push_data, .pc_pop,
    .pc_load, .pc_load_data, .instr_end, .pc(pc_in));

  // ==========================================================================
  // Clock, timeout and verdict
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Shared bus, core and entry helpers
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask
  task rd_zero(input logic [7:0] a);
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    @(negedge clk); `CHK(reg_rdata, 8'h00)
  endtask
  task go(input logic r);
    @(posedge clk); run <= r;
  endtask
  task no_take(input int n);
    repeat (n) begin
      @(negedge clk); `CHK(irq_taken, 1'b0)
    end
  endtask
  task serve(input logic [11:0] v, input flag_set_t fs);
    int n;
    n = 0;
    @(negedge clk);
    while (irq_taken !== 1'b1 && n < 40) begin
      @(negedge clk); n++;
    end
    `CHK(irq_taken, 1'b1)
    repeat (2) @(negedge clk);
    `CHK(pc_push, 1'b1)
    `CHK(pc_push_data, pc_in)
    `CHK(flag_set, fs)
    `CHK(active_source, (v == VEC_SRC0) ? 3'd0 : 3'd4 - v[3:1])
    repeat (2) @(negedge clk);
    `CHK(pc_load, 1'b1)
    `CHK(pc_load_data, v)
  endtask
  task ret(input flag_set_t fs);
    @(posedge clk); run <= 1'b0; return_from_service <= 1'b1;
    @(negedge clk); `CHK(pc_pop, 1'b1)
    @(posedge clk); return_from_service <= 1'b0;
    @(negedge clk); `CHK(flag_set, fs)
  endtask

  // ==========================================================================
  // Scenarios
  task t_regs;
    rd_zero(8'hc8);
    wr(8'hc8, 8'h8f); // Unused bits only
    wr(8'hc9, 8'h10); // Unmapped address
    @(posedge clk); ev[4] <= 1'b1; mk[4] <= 1'b1;
    go(1'b1); no_take(12);
    rd_zero(8'hc8);
    @(posedge clk); ev <= 7'h00; mk <= 7'h00;
  endtask
  task t_nmi;
    go(1'b0); @(posedge clk); core_sleeping <= 1'b1; port_c_irq <= 8'hfe;
    repeat (6) @(posedge clk);
    no_take(3); `CHK(wake_up, 1'b0)
    wr(8'hc8, 8'h10); @(negedge clk); `CHK(wake_up, 1'b1)
    wr(8'hc8, 8'h00);
    @(posedge clk); core_sleeping <= 1'b0; port_c_irq <= 8'hff;
    go(1'b1); serve(VEC_SRC0, FSET_NMI);
    ret(FSET_NORMAL);
    go(1'b1); no_take(12);
  endtask
  task t_periph;
    wr(8'hc8, 8'h10);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk); ev[i] <= 1'b1;
      go(1'b1); no_take(8);
      @(posedge clk); mk[i] <= 1'b1;
      serve((i < 4) ? VEC_SRC4 : VEC_SRC3, FSET_SERVICE);
      @(posedge clk); ev <= 7'h00; mk <= 7'h00;
      ret(FSET_NORMAL);
    end
  endtask
  task t_race;
    @(posedge clk); ldi_option_clear <= 1'b1; ldi_cycle <= 2'h1; ev[5] <= 1'b1; mk[5] <= 1'b1;
    go(1'b1); serve(VEC_SRC3, FSET_NORMAL);
    @(posedge clk); ev <= 7'h00; mk <= 7'h00;
    ret(FSET_NORMAL);
    // Last load cycle lies outside the race window, so the swap happens
    @(posedge clk); ldi_cycle <= 2'h3; ev[5] <= 1'b1; mk[5] <= 1'b1;
    go(1'b1); serve(VEC_SRC3, FSET_SERVICE);
    @(posedge clk); ldi_option_clear <= 1'b0; ldi_cycle <= 2'h0; ev <= 7'h00; mk <= 7'h00;
    ret(FSET_NORMAL);
  endtask
  task t_prio;
    go(1'b0); wr(8'hc8, 8'h50);
    @(posedge clk); port_a_irq <= 8'hfe; ev[0] <= 1'b1; mk[0] <= 1'b1;
    repeat (5) @(posedge clk);
    go(1'b1); serve(VEC_SRC1, FSET_SERVICE);
    @(posedge clk); port_a_irq <= 8'hff;
    no_take(9);
    ret(FSET_NORMAL);
    go(1'b1); serve(VEC_SRC4, FSET_SERVICE);
    @(posedge clk); ev <= 7'h00; mk <= 7'h00;
    ret(FSET_NORMAL);
  endtask
  task t_level;
    // Level pulse removed before sampling leaves nothing behind
    go(1'b0); @(posedge clk); sync_serial_done_n <= 1'b0;
    repeat (6) @(posedge clk); sync_serial_done_n <= 1'b1;
    repeat (4) @(posedge clk);
    go(1'b1); no_take(12);
    go(1'b0); wr(8'hc8, 8'h10);
    @(posedge clk); port_a_irq <= 8'hfe;
    repeat (5) @(posedge clk); port_a_irq <= 8'hff;
    go(1'b1); serve(VEC_SRC1, FSET_SERVICE);
    ret(FSET_NORMAL);
  endtask
  task t_edge;
    go(1'b0); wr(8'hc8, 8'h30);
    @(posedge clk); port_b_irq <= 8'h00;
    repeat (4) @(posedge clk); port_b_irq <= 8'hff;
    repeat (5) @(posedge clk);
    go(1'b1); serve(VEC_SRC2, FSET_SERVICE);
    // Two rising edges on port D while in service
    repeat (2) begin
      @(posedge clk); port_d_irq <= 8'h00;
      repeat (3) @(posedge clk); port_d_irq <= 8'hff;
      repeat (3) @(posedge clk);
    end
    no_take(6);
    ret(FSET_NORMAL);
    go(1'b1); serve(VEC_SRC2, FSET_SERVICE);
    ret(FSET_NORMAL);
    go(1'b1); no_take(12);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    clk = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 8'h00; ldi_option_clear = 1'b0; ldi_cycle = 2'h0; run = 1'b0;
    return_from_service = 1'b0; core_sleeping = 1'b0; sync_serial_done_n = 1'b1;
    port_a_irq = 8'hff; port_b_irq = 8'hff; port_c_irq = 8'hff; port_d_irq = 8'hff;
    ev = 7'h00; mk = 7'h00; bad_count = 0; samples_checked = 0; cyc = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_nmi();
    t_periph();
    t_race();
    t_prio();
    t_level();
    t_edge();
    test_done();
  end
endmodule
